/* File: design/rst_dbg_pin_cfg.sv */
// reset pin and debug pin configuration with its register port
`include "rst_dbg_pin_map.svh"

module rst_dbg_pin_cfg #(
  parameter int unsigned ADDR_W          = 20,
  parameter logic [31:0] DESC_START_ADDR = 32'h00000000,
  parameter int unsigned MIN_CYCLES      = `RST_FILT_CYCLES
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [31:0]            o_rdata,
  output logic                   o_sysext_access,
  input  wire logic              i_rst_pin,
  output logic                   o_pin_pull_en,
  output logic                   o_pin_pull_up,
  output logic                   o_pin_reset_req,
  output logic                   o_ext_nmi_req,
  input  wire logic [3:0]        i_dbg_pin_in,
  output logic [3:0]             o_dbg_pin_out,
  output logic [3:0]             o_dbg_pin_oe_n,
  input  wire logic [3:0]        i_port_out,
  input  wire logic [3:0]        i_port_oe_n,
  output logic [3:0]             o_port_in,
  output logic                   o_jtag_mode,
  output logic                   o_jtag_tck,
  output logic                   o_jtag_tms,
  output logic                   o_jtag_tdi,
  input  wire logic              i_jtag_tdo,
  input  wire logic              i_jtag_tdo_en
);
  localparam logic [ADDR_W-1:0] A_IE   = ADDR_W'(`OFS_NMI_IE);
  localparam logic [ADDR_W-1:0] A_IFG  = ADDR_W'(`OFS_NMI_IFG);
  localparam logic [ADDR_W-1:0] A_RPC  = ADDR_W'(`OFS_RPC);
  localparam logic [ADDR_W-1:0] A_DBG  = ADDR_W'(`OFS_DBG_SEL);
  localparam logic [ADDR_W-1:0] A_DESC = ADDR_W'(`OFS_DESC_START);
  localparam logic [ADDR_W-1:0] A_SYSX = ADDR_W'(`SYSEXT_LAST);

  // pin order: 0 data out, 1 data in, 2 mode select, 3 clock
  localparam int unsigned PIN_TDO = 0;
  localparam int unsigned PIN_TDI = 1;
  localparam int unsigned PIN_TMS = 2;
  localparam int unsigned PIN_TCK = 3;

  rst_dbg_pin_pkg::ctrl_reg_t st_ff;
  rst_dbg_pin_pkg::ctrl_reg_t nxt_st;
  logic [3:0]                 jtag_out;
  logic [3:0]                 jtag_oe_n;

  rst_pin_if pc ();

  function automatic logic word_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    word_hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  function automatic logic in_sysext(input logic [ADDR_W-1:0] addr);
    in_sysext = (addr <= A_SYSX);
  endfunction

  assign pc.pin_level    = i_rst_pin;
  assign pc.nmi_mode     = st_ff.nmi_sel;  // see R2
  assign pc.edge_falling = st_ff.edge_fall;

  rst_pulse_filter #(
    .MIN_CYCLES (MIN_CYCLES)
  ) u_filter (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .pins       (pc)
  );

  nmi_edge_detect u_edge (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .pins       (pc)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata  = 32'h00000000;
    nxt_st.sysext = 1'b0;
    if (i_wr) begin
      if (in_sysext(i_addr)) begin
        nxt_st.sysext = 1'b1;  // see R13
      end else if (word_hit(i_addr, A_IE)) begin
        nxt_st.nmi_ie = i_wdata[`BIT_NMI_IE];
      end else if (word_hit(i_addr, A_IFG)) begin
        if (i_wdata[`BIT_NMI_FLAG]) begin
          nxt_st.nmi_flag = 1'b0;  // see R15
        end
      end else if (word_hit(i_addr, A_RPC)) begin
        nxt_st.nmi_sel   = i_wdata[`BIT_NMI_SEL];  // see R2
        nxt_st.edge_fall = i_wdata[`BIT_EDGE_FALL];  // see R3
        nxt_st.pull_up   = i_wdata[`BIT_PULL_UP];  // see R6
        nxt_st.pull_en   = i_wdata[`BIT_PULL_EN];  // see R6
      end else if (word_hit(i_addr, A_DBG)) begin
        if (i_wdata[`BIT_DBG_SEL]) begin
          nxt_st.jtag_sel = 1'b1;  // see R12
        end
      end
    end
    if (i_rd) begin
      if (in_sysext(i_addr)) begin
        nxt_st.sysext = 1'b1;  // see R13
      end else if (word_hit(i_addr, A_IE)) begin
        nxt_st.rdata[`BIT_NMI_IE] = st_ff.nmi_ie;
      end else if (word_hit(i_addr, A_IFG)) begin
        nxt_st.rdata[`BIT_NMI_FLAG] = st_ff.nmi_flag;
      end else if (word_hit(i_addr, A_RPC)) begin
        nxt_st.rdata[`BIT_NMI_SEL]   = st_ff.nmi_sel;
        nxt_st.rdata[`BIT_EDGE_FALL] = st_ff.edge_fall;
        nxt_st.rdata[`BIT_PULL_UP]   = st_ff.pull_up;
        nxt_st.rdata[`BIT_PULL_EN]   = st_ff.pull_en;
      end else if (word_hit(i_addr, A_DBG)) begin
        nxt_st.rdata[`BIT_DBG_SEL] = st_ff.jtag_sel;
      end else if (word_hit(i_addr, A_DESC)) begin
        nxt_st.rdata = DESC_START_ADDR;  // see R14
      end else begin
        nxt_st.rdata = `VACANT_READ;
      end
    end
    // an edge in the clearing cycle keeps the flag
    if (pc.nmi_edge) begin
      nxt_st.nmi_flag = 1'b1;  // see R5
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff.nmi_sel   <= `RST_NMI_SEL;  // see R1
      st_ff.edge_fall <= `RST_EDGE_FALL;
      st_ff.pull_up   <= `RST_PULL_UP;
      st_ff.pull_en   <= `RST_PULL_EN;
      st_ff.nmi_ie    <= `RST_NMI_IE;
      st_ff.nmi_flag  <= 1'b0;
      st_ff.jtag_sel  <= `RST_DBG_SEL;  // see R9
      st_ff.sysext    <= 1'b0;
      st_ff.rdata     <= 32'h00000000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata         = st_ff.rdata;
  assign o_sysext_access = st_ff.sysext;
  assign o_pin_pull_en   = st_ff.pull_en;  // see R6
  assign o_pin_pull_up   = st_ff.pull_up;  // see R6
  assign o_pin_reset_req = pc.filt_reset;  // see R7
  assign o_ext_nmi_req   = st_ff.nmi_flag && st_ff.nmi_ie;  // see R4
  assign o_jtag_mode     = st_ff.jtag_sel;  // see R11

  // in jtag use only the data-out pin may drive
  assign jtag_out  = {3'h0, i_jtag_tdo};
  assign jtag_oe_n = {3'h7, !i_jtag_tdo_en};

  for (genvar k = 0; k < 4; k++) begin : g_pin
    always_comb begin
      if (st_ff.jtag_sel) begin
        o_dbg_pin_out[k]  = jtag_out[k];  // see R11
        o_dbg_pin_oe_n[k] = jtag_oe_n[k];
        o_port_in[k]      = 1'b0;
      end else begin
        o_dbg_pin_out[k]  = i_port_out[k];  // see R10
        o_dbg_pin_oe_n[k] = i_port_oe_n[k];
        o_port_in[k]      = i_dbg_pin_in[k];
      end
    end
  end

  assign o_jtag_tck = st_ff.jtag_sel && i_dbg_pin_in[PIN_TCK];
  assign o_jtag_tms = st_ff.jtag_sel && i_dbg_pin_in[PIN_TMS];
  assign o_jtag_tdi = st_ff.jtag_sel && i_dbg_pin_in[PIN_TDI];

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_reset_use_quiet: assert property ( // see R1
    !st_ff.nmi_sel ##1 !st_ff.nmi_sel |-> !pc.nmi_edge)
    else $error("nmi edge while pin in reset use");
  chk_fall_to_flag: assert property ( // see R2
    st_ff.nmi_sel && st_ff.edge_fall && $past(i_rst_pin) && !i_rst_pin |-> ##2 st_ff.nmi_flag)
    else $error("falling edge did not set nmi flag");
  chk_req_gated: assert property ( // see R4
    !st_ff.nmi_ie |-> !o_ext_nmi_req)
    else $error("nmi requested while disabled");
  chk_req_follows: assert property ( // see R4
    st_ff.nmi_ie && pc.nmi_edge |=> o_ext_nmi_req)
    else $error("enabled nmi edge gave no request");
  chk_edge_sets_flag: assert property ( // see R5
    pc.nmi_edge |=> st_ff.nmi_flag)
    else $error("edge did not set nmi flag");
  chk_flag_sticky: assert property ( // see R15
    st_ff.nmi_flag && !(i_wr && word_hit(i_addr, A_IFG) && i_wdata[`BIT_NMI_FLAG]) |=> st_ff.nmi_flag)
    else $error("nmi flag dropped without a clear");
  chk_pull_write: assert property ( // see R6
    i_wr && word_hit(i_addr, A_RPC) && !in_sysext(i_addr)
      |=> o_pin_pull_up == $past(i_wdata[`BIT_PULL_UP]) && o_pin_pull_en == $past(i_wdata[`BIT_PULL_EN]))
    else $error("pull controls did not take the write");
  chk_gpio_pass: assert property ( // see R10
    !st_ff.jtag_sel |-> o_dbg_pin_out == i_port_out && o_dbg_pin_oe_n == i_port_oe_n)
    else $error("debug pins not under port control");
  chk_jtag_sticky: assert property ( // see R11
    st_ff.jtag_sel |=> st_ff.jtag_sel ##1 st_ff.jtag_sel)
    else $error("jtag use left before brownout");
  chk_zero_ignored: assert property ( // see R12
    !st_ff.jtag_sel && !(i_wr && word_hit(i_addr, A_DBG) && i_wdata[`BIT_DBG_SEL]) |=> !st_ff.jtag_sel)
    else $error("debug select set without a write of one");
  chk_sysext_read: assert property ( // see R13
    i_rd && in_sysext(i_addr) |=> o_rdata == 32'h00000000 && o_sysext_access)
    else $error("system extension read not reserved");
  chk_desc_read: assert property ( // see R14
    i_rd && word_hit(i_addr, A_DESC) |=> o_rdata == DESC_START_ADDR ##1 o_rdata == 32'h00000000 || $past(i_rd))
    else $error("descriptor start address misread");

  cov_nmi_flag: cover property ($rose(st_ff.nmi_flag) && st_ff.nmi_ie);
  cov_jtag_enter: cover property ($rose(st_ff.jtag_sel));
  cov_set_over_clear: cover property (pc.nmi_edge && i_wr && word_hit(i_addr, A_IFG) && i_wdata[`BIT_NMI_FLAG]);
  cov_desc_read: cover property (i_rd && word_hit(i_addr, A_DESC));
endmodule

/* File: design/rst_dbg_pin_map.svh */
// offsets, field positions, reset values and timing counts of the reset/debug pin block
// What this block does
// R1: After reset the shared reset pin works as a device reset input until software picks the interrupt use.
// R2: Setting the pin NMI select bit turns the reset pin into an external non-maskable interrupt source.
// R3: In interrupt use the pin is edge detected, with the polarity picked by the NMI edge select bit.
// R4: The external NMI is requested only while the external NMI enable bit is set.
// R5: Every qualifying edge in interrupt use sets the external NMI flag.
// R6: The pull direction bit picks pullup or pulldown and the pull enable bit connects that resistor.
// R7: In reset use the pin passes a digital filter that drops pulses shorter than the minimum reset time.
// R8: The short-pulse filter is bypassed while the pin is the external NMI source.
// R9: Every brownout reset clears the debug pin select bit.
// R10: While the debug pin select bit is clear the debug pins are general-purpose I/O under port control.
// R11: Once the debug pin select bit is set the pins run 4-wire JTAG until the next brownout reset.
// R12: Writing zero to the debug pin select bit does nothing, so it is set once per brownout period.
// R13: The decoder treats the lowest byte range of the map as reserved system extension space.
// R14: The map holds a read-only word with the start address of the descriptor structure.
// R15: The external NMI flag stays set until software clears it, and a new edge while set keeps it set.
`ifndef RST_DBG_PIN_MAP_SVH
`define RST_DBG_PIN_MAP_SVH

`define OFS_NMI_IE       20'h00100
`define OFS_NMI_IFG      20'h00104
`define OFS_RPC          20'h00108
`define OFS_DBG_SEL      20'h0010C
`define OFS_DESC_START   20'h00FF4
`define SYSEXT_LAST      20'h000FF

`define BIT_NMI_SEL      0
`define BIT_EDGE_FALL    1
`define BIT_PULL_UP      2
`define BIT_PULL_EN      3
`define BIT_NMI_IE       0
`define BIT_NMI_FLAG     0
`define BIT_DBG_SEL      0

`define RST_NMI_SEL      1'h0
`define RST_EDGE_FALL    1'h0
`define RST_PULL_UP      1'h1
`define RST_PULL_EN      1'h1
`define RST_NMI_IE       1'h0
`define RST_DBG_SEL      1'h0
`define VACANT_READ      32'h00003FFF

`define CLK_PERIOD_NS    5
`define RST_MIN_PULSE_NS 2000
`define RST_FILT_CYCLES  ((`RST_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: design/rst_dbg_pin_pkg.sv */
// state types of the reset/debug pin block
package rst_dbg_pin_pkg;

  typedef enum logic [2:0] {
    FILT_IDLE   = 3'h1,
    FILT_COUNT  = 3'h2,
    FILT_ACTIVE = 3'h4
  } filt_fsm_t;

  typedef struct packed {
    filt_fsm_t   fsm;
    logic [15:0] cnt;
    logic        req;
  } filt_reg_t;

  typedef struct packed {
    logic pin_d;
    logic edge_seen;
  } edge_reg_t;

  typedef struct packed {
    logic        nmi_sel;
    logic        edge_fall;
    logic        pull_up;
    logic        pull_en;
    logic        nmi_ie;
    logic        nmi_flag;
    logic        jtag_sel;
    logic        sysext;
    logic [31:0] rdata;
  } ctrl_reg_t;

endpackage

/* File: design/rst_pin_if.sv */
// signals shared between the pin control and its filter and edge detector
interface rst_pin_if;
  logic pin_level;
  logic nmi_mode;
  logic edge_falling;
  logic nmi_edge;
  logic filt_reset;

  modport ctrl (output pin_level, output nmi_mode, output edge_falling, input nmi_edge, input filt_reset);
  modport filt (input pin_level, input nmi_mode, output filt_reset);
  modport edet (input pin_level, input nmi_mode, input edge_falling, output nmi_edge);
endinterface

/* File: design/rst_pulse_filter.sv */
// short-pulse filter on the active-low reset pin
`include "rst_dbg_pin_map.svh"
module rst_pulse_filter #(
  parameter int unsigned MIN_CYCLES = `RST_FILT_CYCLES
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  rst_pin_if.filt   pins
);
  localparam logic [15:0] LAST = 16'(MIN_CYCLES - 1);

  rst_dbg_pin_pkg::filt_reg_t st_ff;
  rst_dbg_pin_pkg::filt_reg_t nxt_st;
  logic [15:0]                low_run_ff;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff.fsm)
      rst_dbg_pin_pkg::FILT_IDLE: begin
        nxt_st.cnt = 16'h0000;
        if (!pins.pin_level) begin
          nxt_st.fsm = (LAST == 16'h0000) ? rst_dbg_pin_pkg::FILT_ACTIVE : rst_dbg_pin_pkg::FILT_COUNT;
          nxt_st.cnt = 16'h0001;
        end
      end
      rst_dbg_pin_pkg::FILT_COUNT: begin
        if (pins.pin_level) begin
          nxt_st.fsm = rst_dbg_pin_pkg::FILT_IDLE;  // see R7
        end else if (st_ff.cnt >= LAST) begin
          nxt_st.fsm = rst_dbg_pin_pkg::FILT_ACTIVE;
        end else begin
          nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
      end
      rst_dbg_pin_pkg::FILT_ACTIVE: begin
        if (pins.pin_level) begin
          nxt_st.fsm = rst_dbg_pin_pkg::FILT_IDLE;
        end
      end
      default: nxt_st.fsm = rst_dbg_pin_pkg::FILT_IDLE;
    endcase
    if (pins.nmi_mode) begin
      nxt_st.fsm = rst_dbg_pin_pkg::FILT_IDLE;  // see R8
      nxt_st.cnt = 16'h0000;
    end
    nxt_st.req = (nxt_st.fsm == rst_dbg_pin_pkg::FILT_ACTIVE);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '{fsm: rst_dbg_pin_pkg::FILT_IDLE, cnt: 16'h0000, req: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pins.filt_reset = st_ff.req;

  // consecutive low samples in reset use, watched only by checks
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_run_ff <= 16'h0000;
    end else if (pins.pin_level || pins.nmi_mode) begin
      low_run_ff <= 16'h0000;
    end else if (low_run_ff != 16'hFFFF) begin
      low_run_ff <= low_run_ff + 16'h0001;
    end
  end

  chk_filter_min_low: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R7
    $rose(pins.filt_reset) |-> low_run_ff == LAST + 16'h0001)
    else $error("filtered reset rose before the minimum low time");
  chk_filter_bypass: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R8
    pins.nmi_mode |=> !pins.filt_reset)
    else $error("reset filter active in nmi use");
  chk_filter_release: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R7
    pins.filt_reset && pins.pin_level |=> !pins.filt_reset)
    else $error("filtered reset held after pin release");
  cov_filter_reset: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) $rose(pins.filt_reset));
endmodule

/* File: design/nmi_edge_detect.sv */
// edge detector for the reset pin in nmi use
module nmi_edge_detect (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  rst_pin_if.edet   pins
);
  rst_dbg_pin_pkg::edge_reg_t st_ff;
  rst_dbg_pin_pkg::edge_reg_t nxt_st;
  logic                       rise;
  logic                       fall;

  always_comb begin
    rise = pins.pin_level && !st_ff.pin_d;
    fall = !pins.pin_level && st_ff.pin_d;
    nxt_st = st_ff;
    nxt_st.pin_d = pins.pin_level;
    nxt_st.edge_seen = pins.nmi_mode && (pins.edge_falling ? fall : rise);  // see R3
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '{pin_d: 1'b1, edge_seen: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pins.nmi_edge = st_ff.edge_seen;

  chk_edge_polarity: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R3
    pins.nmi_mode && !pins.edge_falling && pins.pin_level && !st_ff.pin_d |=> pins.nmi_edge)
    else $error("rising edge missed in nmi use");
  chk_edge_only: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R3
    pins.nmi_edge |-> $past(pins.pin_level, 2) != $past(pins.pin_level))
    else $error("nmi edge without a pin transition");
endmodule

/* File: sim/rst_jtag_partner.sv */
// reset source and jtag probe on the far side of the reset and debug pins
module rst_jtag_partner (
  input  wire logic       i_core_clk,
  input  wire logic [3:0] i_dbg_out,
  input  wire logic [3:0] i_dbg_oe_n,
  output logic            o_rst_pin,
  output logic [3:0]      o_dbg_lvl
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] drv_en;
  logic [3:0] drv_val;
  logic [3:0] float_val;

  initial begin
    o_rst_pin = 1'b1;
    drv_en    = 4'h0;
    drv_val   = 4'h0;
    float_val = 4'h5;
  end

  // released pins wander so a stale level never passes
  always @(posedge i_core_clk) begin
    float_val <= ~float_val;
  end

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_dbg_lvl[k] = !i_dbg_oe_n[k] ? i_dbg_out[k] : (drv_en[k] ? drv_val[k] : float_val[k]);
    end
  end

  // level v from next edge; the following call's edge is the n-th sample
  task automatic set_pin(input logic v, input int n);
    @(posedge i_core_clk);
    o_rst_pin <= v;
    repeat (n - 1) @(posedge i_core_clk);
  endtask

  task automatic probe_drive(input logic [3:0] en, input logic [3:0] val);
    @(posedge i_core_clk);
    drv_en  <= en;
    drv_val <= val;
  endtask
endmodule

/* File: sim/rst_dbg_pin_cfg_bench.sv */
// self-checking bench for the reset pin and debug pin configuration
`include "rst_dbg_pin_map.svh"

module rst_dbg_pin_cfg_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] DESC = 32'h00012340;

  logic        i_core_clk, i_rst_n, i_wr, i_rd, i_rst_pin, o_sysext_access;
  logic        o_pin_pull_en, o_pin_pull_up, o_pin_reset_req, o_ext_nmi_req, o_jtag_mode;
  logic        o_jtag_tck, o_jtag_tms, o_jtag_tdi, i_jtag_tdo, i_jtag_tdo_en, last_sysext;
  logic [19:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0]  i_dbg_pin_in, o_dbg_pin_out, o_dbg_pin_oe_n, i_port_out, i_port_oe_n, o_port_in;
  int          failures;
  int          check_count;

  rst_dbg_pin_cfg #(.ADDR_W(20), .DESC_START_ADDR(DESC), .MIN_CYCLES(3)) i_dut (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_sysext_access(o_sysext_access),
    .i_rst_pin(i_rst_pin), .o_pin_pull_en(o_pin_pull_en), .o_pin_pull_up(o_pin_pull_up),
    .o_pin_reset_req(o_pin_reset_req), .o_ext_nmi_req(o_ext_nmi_req), .i_dbg_pin_in(i_dbg_pin_in),
    .o_dbg_pin_out(o_dbg_pin_out), .o_dbg_pin_oe_n(o_dbg_pin_oe_n), .i_port_out(i_port_out),
    .i_port_oe_n(i_port_oe_n), .o_port_in(o_port_in), .o_jtag_mode(o_jtag_mode),
    .o_jtag_tck(o_jtag_tck), .o_jtag_tms(o_jtag_tms), .o_jtag_tdi(o_jtag_tdi),
    .i_jtag_tdo(i_jtag_tdo), .i_jtag_tdo_en(i_jtag_tdo_en));

  rst_jtag_partner i_probe (
    .i_core_clk(i_core_clk), .i_dbg_out(o_dbg_pin_out), .i_dbg_oe_n(o_dbg_pin_oe_n),
    .o_rst_pin(i_rst_pin), .o_dbg_lvl(i_dbg_pin_in));

  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  task automatic check_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_pin(input string what, input logic [3:0] exp, input logic [3:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic write_reg(input logic [19:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask

  task automatic read_reg(input logic [19:0] a, input logic [31:0] exp);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    last_sysext = o_sysext_access;
    check_reg($sformatf("read %h", a), exp, o_rdata);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic test_end(input string name);
    $display("test %s done, %0d mismatches so far", name, failures);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_core_clk);
    failures++;
    conclude();
  end

  initial begin
    {i_rst_n, i_addr, i_wdata, i_wr, i_rd, i_jtag_tdo, i_jtag_tdo_en} = '0;
    i_port_out  = 4'hA;
    i_port_oe_n = 4'h0;
    failures    = 0;
    check_count = 0;
    repeat (6) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    read_reg(`OFS_RPC, 32'h0000000C);
    check_pin("pull", 4'h3, {2'h0, o_pin_pull_en, o_pin_pull_up});
    read_reg(`OFS_NMI_IE, 32'h0);
    read_reg(`OFS_NMI_IFG, 32'h0);
    read_reg(`OFS_DBG_SEL, 32'h0);
    write_reg(`OFS_DESC_START, 32'hFFFFFFFF);
    read_reg(`OFS_DESC_START, DESC);
    read_reg(20'h00200, `VACANT_READ);
    check_pin("sysext", 4'h0, {3'h0, last_sysext});
    write_reg(20'h000FC, 32'hFFFFFFFF);
    settle(0);
    check_pin("sysext", 4'h1, {3'h0, o_sysext_access});
    read_reg(20'h000FC, 32'h0);
    check_pin("sysext", 4'h1, {3'h0, last_sysext});
    test_end("map");
    i_probe.set_pin(1'b0, 2);
    i_probe.set_pin(1'b1, 1);
    settle(0);
    check_pin("rst req", 4'h0, {3'h0, o_pin_reset_req});
    settle(3);
    check_pin("rst req", 4'h0, {3'h0, o_pin_reset_req});
    i_probe.set_pin(1'b0, 3);
    i_probe.set_pin(1'b1, 1);
    settle(0);
    check_pin("rst req", 4'h1, {3'h0, o_pin_reset_req});
    settle(3);
    check_pin("rst req", 4'h0, {3'h0, o_pin_reset_req});
    write_reg(`OFS_RPC, 32'h8);
    settle(0);
    check_pin("pull", 4'h2, {2'h0, o_pin_pull_en, o_pin_pull_up});
    write_reg(`OFS_RPC, 32'h4);
    settle(0);
    check_pin("pull", 4'h1, {2'h0, o_pin_pull_en, o_pin_pull_up});
    test_end("filter");
    write_reg(`OFS_RPC, 32'hF);
    write_reg(`OFS_NMI_IE, 32'h1);
    i_probe.set_pin(1'b0, 6);
    settle(0);
    check_pin("rst req", 4'h0, {3'h0, o_pin_reset_req});
    check_pin("nmi req", 4'h1, {3'h0, o_ext_nmi_req});
    write_reg(`OFS_NMI_IFG, 32'h0);
    read_reg(`OFS_NMI_IFG, 32'h1);
    write_reg(`OFS_NMI_IFG, 32'h1);
    read_reg(`OFS_NMI_IFG, 32'h0);
    i_probe.set_pin(1'b1, 4);
    read_reg(`OFS_NMI_IFG, 32'h0);
    write_reg(`OFS_NMI_IE, 32'h0);
    i_probe.set_pin(1'b0, 2);
    i_probe.set_pin(1'b1, 4);
    settle(0);
    check_pin("nmi req", 4'h0, {3'h0, o_ext_nmi_req});
    read_reg(`OFS_NMI_IFG, 32'h1);
    i_probe.set_pin(1'b0, 2);
    i_probe.set_pin(1'b1, 4);
    read_reg(`OFS_NMI_IFG, 32'h1);
    write_reg(`OFS_NMI_IE, 32'h1);
    settle(0);
    check_pin("nmi req", 4'h1, {3'h0, o_ext_nmi_req});
    write_reg(`OFS_RPC, 32'hD);
    write_reg(`OFS_NMI_IFG, 32'h1);
    i_probe.set_pin(1'b0, 4);
    read_reg(`OFS_NMI_IFG, 32'h0);
    i_probe.set_pin(1'b1, 4);
    read_reg(`OFS_NMI_IFG, 32'h1);
    write_reg(`OFS_RPC, 32'hC);
    write_reg(`OFS_NMI_IFG, 32'h1);
    i_probe.set_pin(1'b0, 4);
    i_probe.set_pin(1'b1, 1);
    settle(0);
    check_pin("rst req", 4'h1, {3'h0, o_pin_reset_req});
    read_reg(`OFS_NMI_IFG, 32'h0);
    test_end("nmi");
    settle(0);
    check_pin("dbg out", 4'hA, o_dbg_pin_out);
    check_pin("dbg oe", 4'h0, o_dbg_pin_oe_n);
    check_pin("port in", 4'hA, o_port_in);
    @(posedge i_core_clk);
    i_port_oe_n <= 4'hF;
    i_probe.probe_drive(4'hF, 4'h5);
    settle(0);
    check_pin("port in", 4'h5, o_port_in);
    check_pin("dbg oe", 4'hF, o_dbg_pin_oe_n);
    check_pin("jtag in", 4'h0, {1'b0, o_jtag_tck, o_jtag_tms, o_jtag_tdi});
    write_reg(`OFS_DBG_SEL, 32'h0);
    settle(0);
    check_pin("jtag mode", 4'h0, {3'h0, o_jtag_mode});
    write_reg(`OFS_DBG_SEL, 32'h1);
    read_reg(`OFS_DBG_SEL, 32'h1);
    @(posedge i_core_clk);
    i_port_oe_n   <= 4'h0;
    i_port_out    <= 4'h5;
    i_jtag_tdo_en <= 1'b1;
    i_probe.probe_drive(4'hE, 4'hA);
    settle(0);
    check_pin("jtag in", 4'h5, {1'b0, o_jtag_tck, o_jtag_tms, o_jtag_tdi});
    check_pin("dbg oe", 4'hE, o_dbg_pin_oe_n);
    check_pin("tdo", 4'h0, {3'h0, o_dbg_pin_out[0]});
    check_pin("port in", 4'h0, o_port_in);
    @(posedge i_core_clk);
    i_jtag_tdo <= 1'b1;
    settle(1);
    check_pin("tdo", 4'h1, {3'h0, o_dbg_pin_out[0]});
    i_probe.probe_drive(4'hE, 4'h4);
    settle(0);
    check_pin("jtag in", 4'h2, {1'b0, o_jtag_tck, o_jtag_tms, o_jtag_tdi});
    write_reg(`OFS_DBG_SEL, 32'h0);
    read_reg(`OFS_DBG_SEL, 32'h1);
    check_pin("jtag mode", 4'h1, {3'h0, o_jtag_mode});
    @(posedge i_core_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    settle(0);
    check_pin("jtag mode", 4'h0, {3'h0, o_jtag_mode});
    check_pin("dbg out", 4'h5, o_dbg_pin_out);
    read_reg(`OFS_DBG_SEL, 32'h0);
    test_end("debug pins");
    conclude();
  end
endmodule
